// ---- crcg_cfg.svh ----
/*
  register map, field positions, reset values and sizes of the crc generator.
  assumes inclusion by its bare name from the package and the top module.
*/
`ifndef CRCG_CFG_SVH
`define CRCG_CFG_SVH

// ----------------------------------------
// word offsets on the avalon slave
// ----------------------------------------
`define CRCG_OFS_CTRL1     3'h0
`define CRCG_OFS_CTRL2     3'h1
`define CRCG_OFS_DATA      3'h2
`define CRCG_OFS_RESULT    3'h3
`define CRCG_OFS_POLY      3'h4
`define CRCG_OFS_IRQSTAT   3'h5
`define CRCG_OFS_IRQMASK   3'h6

// ----------------------------------------
// control one fields
// ----------------------------------------
`define CRCG_C1_COUNT_LSB  8
`define CRCG_C1_FULL       7
`define CRCG_C1_EMPTY      6
`define CRCG_C1_ISEL       5
`define CRCG_C1_GO         4
`define CRCG_C1_LSBF       3

// ----------------------------------------
// control two fields
// ----------------------------------------
`define CRCG_C2_WIDTH_LSB  8
`define CRCG_C2_PLEN_LSB   0

// ----------------------------------------
// interrupt status bits and reset values
// ----------------------------------------
`define CRCG_IRQ_CRC       0
`define CRCG_IRQ_DONE      1
`define CRCG_RST_FIELD     5'h00
`define CRCG_RST_WORD      32'h0000_0000

// ----------------------------------------
// fifo sizing
// ----------------------------------------
`define CRCG_DEPTH_SHORT   5'h10
`define CRCG_DEPTH_LONG    5'h08
`define CRCG_PLEN_LONG_MIN 5'h08

`endif

// ---- crcg_ctrl.sv ----
/*
  crc generator: avalon-mm register slave, input fifo, serial shifter,
  lfsr engine and interrupt logic.
  assumes an avalon-mm master on clk_sys and a level interrupt sink.
*/
`timescale 1ns/1ns
`include "crcg_cfg.svh"

module crcg_ctrl #(
  parameter int DATA_W = 32,
  parameter int DEPTH  = 16
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // avalon-mm slave
  input  wire crcg_pkg::crcg_avreq_t avReq,
  output crcg_pkg::crcg_avrsp_t      avRsp,
  // interrupt
  output logic                      irq
);
  import crcg_pkg::*;

  initial begin
    if (DATA_W != 32 || DEPTH != 16) begin
      $error("crcg_ctrl: DATA_W must be 32 and DEPTH 16");
    end
  end

  // ----------------------------------------
  // state and fifo wiring
  // ----------------------------------------
  crcg_state_t st_q, st_d;

  logic              push;
  logic              pop;
  logic [DATA_W-1:0] headData;
  logic [4:0]        capacity;
  logic [4:0]        count;
  logic              fifoFull;
  logic              fifoEmpty;
  logic              busReq;
  logic              wrData;
  logic              accept;
  logic [31:0]       beMask;
  logic [31:0]       wrWord;
  logic [31:0]       polyMask;
  logic              curBit;
  logic              feedback;
  logic              startWord;
  logic              lastBit;
  logic              shiftDone;
  logic              fifoDrained;
  logic              crcEvent;
  logic [31:0]       ctrl1Word;
  logic [31:0]       ctrl2Word;

  assign capacity = (st_q.plenField >= `CRCG_PLEN_LONG_MIN) ? `CRCG_DEPTH_LONG : `CRCG_DEPTH_SHORT;

  crcg_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .push     (push),
    .pushData (avReq.writedata),
    .pop      (pop),
    .headData (headData),
    .capacity (capacity),
    .count    (count),
    .full     (fifoFull),
    .empty    (fifoEmpty)
  );

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // a data write into a full fifo stalls on waitrequest until a word drains
  assign busReq   = avReq.read | avReq.write;
  assign wrData   = avReq.write && avReq.address == `CRCG_OFS_DATA;
  assign accept   = busReq && !st_q.ack && !(wrData && fifoFull);
  assign push     = accept && wrData;
  assign avRsp.waitrequest = busReq && !st_q.ack;
  assign avRsp.readdata    = st_q.rdata;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      beMask[8*i +: 8] = {8{avReq.byteenable[i]}};
    end
  end

  // ----------------------------------------
  // shifter datapath
  // ----------------------------------------
  // polynomial length mask
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      polyMask[i] = (5'(i) <= st_q.plenField);
    end
  end

  assign curBit   = st_q.lsbFirst ? st_q.shReg[0] : st_q.shReg[st_q.widthField];
  assign feedback = curBit ^ st_q.crc[st_q.plenField];

  assign startWord   = st_q.goBit && !fifoEmpty &&
                       (st_q.phase == CRCG_IDLE || (st_q.phase == CRCG_SHIFT && lastBit));
  assign lastBit     = st_q.goBit && st_q.phase == CRCG_SHIFT && st_q.bitCnt == 5'h00;
  assign pop         = startWord;
  assign shiftDone   = lastBit && fifoEmpty;
  assign fifoDrained = pop && count == 5'h01 && !push;

  assign crcEvent = st_q.iselBit ? fifoDrained : shiftDone;

  assign ctrl1Word = {19'h0, count, fifoFull, fifoEmpty, st_q.iselBit, st_q.goBit,
                      st_q.lsbFirst, 3'h0};

  assign ctrl2Word = {19'h0, st_q.widthField, 3'h0, st_q.plenField};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d     = st_q;
    wrWord   = 32'h0;
    st_d.ack = accept;

    if (st_q.goBit && st_q.phase == CRCG_SHIFT) begin
      st_d.crc    = ({st_q.crc[30:0], 1'b0} ^ (feedback ? st_q.poly : 32'h0)) & polyMask;
      st_d.shReg  = st_q.lsbFirst ? {1'b0, st_q.shReg[31:1]} : {st_q.shReg[30:0], 1'b0};
      st_d.bitCnt = st_q.bitCnt - 5'h01;
      if (lastBit) begin
        st_d.phase = CRCG_IDLE;
      end
    end
    if (startWord) begin
      st_d.shReg  = headData;
      st_d.bitCnt = st_q.widthField;
      st_d.phase  = CRCG_SHIFT;
    end

    if (accept && avReq.write) begin
      if (avReq.address == `CRCG_OFS_CTRL1) begin
        wrWord        = (ctrl1Word & ~beMask) | (avReq.writedata & beMask);
        st_d.iselBit  = wrWord[`CRCG_C1_ISEL];
        st_d.goBit    = wrWord[`CRCG_C1_GO];
        st_d.lsbFirst = wrWord[`CRCG_C1_LSBF];
      end else if (avReq.address == `CRCG_OFS_CTRL2) begin
        wrWord          = (ctrl2Word & ~beMask) | (avReq.writedata & beMask);
        st_d.widthField = wrWord[`CRCG_C2_WIDTH_LSB +: 5];
        st_d.plenField  = wrWord[`CRCG_C2_PLEN_LSB +: 5];
      end else if (avReq.address == `CRCG_OFS_RESULT) begin
        // seeding the result only makes sense while the shifter is idle
        st_d.crc = (st_q.crc & ~beMask) | (avReq.writedata & beMask);
      end else if (avReq.address == `CRCG_OFS_POLY) begin
        st_d.poly = (st_q.poly & ~beMask) | (avReq.writedata & beMask);
      end else if (avReq.address == `CRCG_OFS_IRQMASK) begin
        st_d.irqMask = avReq.byteenable[0] ? avReq.writedata[1:0] : st_q.irqMask;
      end
    end

    if (accept && avReq.read) begin
      if (avReq.address == `CRCG_OFS_CTRL1) begin
        st_d.rdata = ctrl1Word;
      end else if (avReq.address == `CRCG_OFS_CTRL2) begin
        st_d.rdata = ctrl2Word;
      end else if (avReq.address == `CRCG_OFS_RESULT) begin
        st_d.rdata = st_q.crc;
      end else if (avReq.address == `CRCG_OFS_POLY) begin
        st_d.rdata = st_q.poly;
      end else if (avReq.address == `CRCG_OFS_IRQSTAT) begin
        st_d.rdata   = {30'h0, st_q.irqStat};
        st_d.irqStat = 2'b00;
      end else if (avReq.address == `CRCG_OFS_IRQMASK) begin
        st_d.rdata = {30'h0, st_q.irqMask};
      end else begin
        st_d.rdata = 32'h0;
      end
    end

    // events set after the read clear, so a coincident event survives
    if (crcEvent) begin
      st_d.irqStat[`CRCG_IRQ_CRC] = 1'b1;
    end
    if (shiftDone) begin
      st_d.irqStat[`CRCG_IRQ_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q            <= '0;
      st_q.phase      <= CRCG_IDLE;
      st_q.widthField <= `CRCG_RST_FIELD;
      st_q.plenField  <= `CRCG_RST_FIELD;
      st_q.poly       <= `CRCG_RST_WORD;
      st_q.crc        <= `CRCG_RST_WORD;
    end else begin
      st_q <= st_d;
    end
  end

  assign irq = |(st_q.irqStat & st_q.irqMask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_word_start;
    startWord;
  endsequence

  sequence s_last_drain;
    fifoDrained && st_q.iselBit;
  endsequence

  sequence s_stop_go;
    !st_q.goBit && st_q.phase == CRCG_SHIFT;
  endsequence

  a_full_flag: assert property (fifoFull == (count >= capacity) && ctrl1Word[`CRCG_C1_FULL] == fifoFull)
    else $error("full flag does not match word count");

  a_empty_flag: assert property ((count == 5'h00) |-> ctrl1Word[`CRCG_C1_EMPTY] ##0 !pop)
    else $error("empty flag low or pop while fifo empty");

  a_irq_early: assert property (s_last_drain |=> st_q.irqStat[`CRCG_IRQ_CRC] && st_q.phase == CRCG_SHIFT)
    else $error("empty-fifo interrupt not raised while last word shifts");

  a_irq_late: assert property ((!st_q.iselBit && !shiftDone) |=> !$rose(st_q.irqStat[`CRCG_IRQ_CRC]))
    else $error("shift-complete interrupt raised before shifting ended");

  a_go_stopped: assert property (s_stop_go |=> $stable(st_q.crc) && $stable(st_q.bitCnt) && !$past(pop))
    else $error("shifter moved while go is clear");

  a_bit_order: assert property (s_word_start ##0 st_q.lsbFirst |=> curBit == $past(headData[0]))
    else $error("lsb-first word does not begin with bit zero");

  a_width_load: assert property (s_word_start |=> st_q.bitCnt == $past(st_q.widthField))
    else $error("bit count not loaded from width field");

  a_zero_bits: assert property ((st_q.ack && $past(avReq.read && avReq.address == `CRCG_OFS_CTRL2))
                                |-> st_q.rdata[15:13] == 3'h0 && st_q.rdata[7:5] == 3'h0)
    else $error("unused control two bits read nonzero");

  a_count_cap: assert property ((st_q.plenField >= `CRCG_PLEN_LONG_MIN && count >= `CRCG_DEPTH_LONG) |-> !push)
    else $error("fifo exceeded eight words with long polynomial");

  a_one_bit: assert property ((st_q.goBit && st_q.phase == CRCG_SHIFT && !startWord)
                              |=> st_q.bitCnt == $past(st_q.bitCnt) - 5'h01)
    else $error("shifter did not consume exactly one bit");

  a_len_mask: assert property (##1 (st_q.crc & ~polyMask) == 32'h0 || $past(accept && avReq.write))
    else $error("crc bits set beyond polynomial length");
endmodule

// ---- crcg_ctrl_tb.sv ----
/*
  self-checking bench of the crc generator, driven over its avalon-mm slave.
  assumes crcg_pkg and crcg_ctrl compiled before it, one clock domain.
*/
`timescale 1ns/1ns
`include "crcg_cfg.svh"
module crcg_ctrl_tb;
  import crcg_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_sys;
  logic        rst;
  crcg_avreq_t avReq;
  crcg_avrsp_t avRsp;
  logic        irq;
  int          errorCnt;
  int          comparisons;
  logic [31:0] rd;
  logic [31:0] words [16];

  crcg_ctrl i_dut (
    .clk_sys (clk_sys),
    .rst     (rst),
    .avReq   (avReq),
    .avRsp   (avRsp),
    .irq     (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // waitrequest and readdata are read right after each rising edge, before the design's flops update,
  // so they are the values that stood at that edge; the request is released only after it
  task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    avReq.address   <= a;
    avReq.read      <= ~wr;
    avReq.write     <= wr;
    avReq.writedata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avRsp.waitrequest !== 1'b0 && n < 500);
    if (n >= 500) begin
      errorCnt++;
      $display("[ERR] waitrequest expected 0 seen 1");
    end
    q = avRsp.readdata;
    avReq.read  <= 1'b0;
    avReq.write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [2:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, rd);
    chk(nm, rd, exp);
  endtask

  task automatic waitIrq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // serial lfsr over the words table, one bit per step
  function automatic logic [31:0] crcModel(input int cnt, input int wf, input int pf, input logic [31:0] poly,
                                           input logic [31:0] seed, input logic lsb);
    logic [31:0] c;
    logic [31:0] mask;
    logic        fb;
    mask = 32'hffff_ffff >> (31 - pf);
    c = seed & mask;
    for (int i = 0; i < cnt; i++) begin
      for (int j = 0; j <= wf; j++) begin
        fb = (lsb ? words[i][j] : words[i][wf - j]) ^ c[pf];
        c = ((c << 1) ^ (fb ? poly : 32'h0)) & mask;
      end
    end
    return c;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk("ctrlOne", `CRCG_OFS_CTRL1, 32'h0000_0040);
    rdchk("ctrlTwo", `CRCG_OFS_CTRL2, 32'h0000_0000);
    rdchk("unmapped", 3'h7, 32'h0000_0000);
    rdchk("irqStat", `CRCG_OFS_IRQSTAT, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_fields;
    wr(`CRCG_OFS_CTRL2, 32'hffff_ffff);
    rdchk("ctrlTwo", `CRCG_OFS_CTRL2, 32'h0000_1f1f);
    $display("test fields done");
  endtask

  task automatic t_msbFill;
    wr(`CRCG_OFS_CTRL1, 32'h0000_0000);
    wr(`CRCG_OFS_CTRL2, 32'h0000_0707);
    wr(`CRCG_OFS_POLY, 32'h0000_0007);
    wr(`CRCG_OFS_RESULT, 32'h0000_0000);
    wr(`CRCG_OFS_IRQMASK, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      words[i] = 32'hc3a5_0000 ^ (i * 32'h0000_1b37);
      wr(`CRCG_OFS_DATA, words[i]);
    end
    rdchk("ctrlOne", `CRCG_OFS_CTRL1, 32'h0000_1080);
    repeat (20) @(posedge clk_sys);
    rdchk("result", `CRCG_OFS_RESULT, 32'h0000_0000);
    wr(`CRCG_OFS_CTRL1, 32'h0000_0030);
    waitIrq(16 * 8 + 40);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    // last word is still in the shifter here, yet the fifo already reads empty
    rdchk("ctrlOne", `CRCG_OFS_CTRL1, 32'h0000_0070);
    repeat (30) @(posedge clk_sys);
    rdchk("irqStat", `CRCG_OFS_IRQSTAT, 32'h0000_0003);
    rdchk("result", `CRCG_OFS_RESULT, crcModel(16, 7, 7, 32'h7, 32'h0, 1'b0));
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test msb fill done");
  endtask

  task automatic t_lsbLong;
    logic [31:0] held;
    wr(`CRCG_OFS_CTRL1, 32'h0000_0000);
    wr(`CRCG_OFS_CTRL2, 32'h0000_0f0f);
    wr(`CRCG_OFS_POLY, 32'h0000_1021);
    wr(`CRCG_OFS_RESULT, 32'h0000_ffff);
    for (int i = 0; i < 8; i++) begin
      words[i] = 32'h1234_5678 + i * 32'h0101_0b0d;
      wr(`CRCG_OFS_DATA, words[i]);
    end
    rdchk("ctrlOne", `CRCG_OFS_CTRL1, 32'h0000_0880);
    wr(`CRCG_OFS_CTRL1, 32'h0000_0018);
    repeat (20) @(posedge clk_sys);
    // clearing go mid-word must freeze the partial crc until go returns
    wr(`CRCG_OFS_CTRL1, 32'h0000_0008);
    bus(`CRCG_OFS_RESULT, 1'b0, 32'h0, held);
    repeat (10) @(posedge clk_sys);
    rdchk("frozen", `CRCG_OFS_RESULT, held);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    wr(`CRCG_OFS_CTRL1, 32'h0000_0018);
    // fifo is empty by now but the last word is mid-shift, so no request yet
    repeat (100) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    waitIrq(60);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    rdchk("irqStat", `CRCG_OFS_IRQSTAT, 32'h0000_0003);
    rdchk("result", `CRCG_OFS_RESULT, crcModel(8, 15, 15, 32'h1021, 32'hffff, 1'b1));
    $display("test lsb long done");
  endtask

  // ----------------------------------------
  // verdict and run control
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errorCnt++;
    results();
  end

  initial begin
    errorCnt    = 0;
    comparisons = 0;
    rst         = 1'b1;
    avReq       = '0;
    avReq.byteenable = 4'hf;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_fields();
    t_msbFill();
    t_lsbLong();
    results();
  end
endmodule

// ---- crcg_fifo.sv ----
/*
  input word fifo of the crc generator with a runtime capacity limit.
  assumes push only while not full and pop only while not empty.
*/
`timescale 1ns/1ns
module crcg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  // read side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] headData,
  // status
  input  wire logic [4:0]       capacity,
  output logic      [4:0]       count,
  output logic                  full,
  output logic                  empty
);
  import crcg_pkg::*;

  initial begin
    if (DEPTH != 16 || WIDTH < 1 || WIDTH > 32) begin
      $error("crcg_fifo: unsupported WIDTH or DEPTH");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [3:0]                  wrPtr;
    logic [3:0]                  rdPtr;
    logic [4:0]                  cnt;
  } crcg_fifo_state_t;

  crcg_fifo_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wrPtr] = pushData;
      st_d.wrPtr           = st_q.wrPtr + 4'h1;
    end
    if (pop) begin
      st_d.rdPtr = st_q.rdPtr + 4'h1;
    end
    st_d.cnt = st_q.cnt + {4'h0, push} - {4'h0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign headData = st_q.mem[st_q.rdPtr];
  assign count    = st_q.cnt;
  assign full     = (st_q.cnt >= capacity);
  assign empty    = (st_q.cnt == 5'h00);
endmodule

// ---- crcg_pkg.sv ----
/*
  types of the crc generator: register state and bus carriers.
  assumes crcg_cfg.svh alongside for the constants.
*/
package crcg_pkg;
  `include "crcg_cfg.svh"

  typedef struct packed {
    logic [2:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } crcg_avreq_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } crcg_avrsp_t;

  typedef enum logic [1:0] {
    CRCG_IDLE  = 2'b01,
    CRCG_SHIFT = 2'b10
  } crcg_phase_t;

  typedef struct packed {
    logic [4:0]  widthField;
    logic [4:0]  plenField;
    logic        iselBit;
    logic        goBit;
    logic        lsbFirst;
    logic [31:0] poly;
    logic [31:0] crc;
    logic [31:0] shReg;
    logic [4:0]  bitCnt;
    crcg_phase_t phase;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  irqStat;
    logic [1:0]  irqMask;
  } crcg_state_t;
endpackage
